/* File: common/sctc_pkg.sv */
// Purpose: Shared constants and carriers for the test and control register block
// Assumes: AXI4-Lite, 32-bit data, 100 MHz clock
// Notes:   Offsets are byte addresses of aligned words
`default_nettype none
package sctc_pkg;

    // ============================================================
    // Register map
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_COMPANION = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT  = 8'h08;
    localparam logic [7:0] OFS_IRQ_EN    = 8'h0C;
    localparam logic [7:0] OFS_IRQ_CLR   = 8'h10;
    localparam logic [7:0] OFS_LINK_STAT = 8'h14;

    // ============================================================
    // Control register fields
    localparam int BIT_RSVD7  = 7;
    localparam int BIT_GAPOFF = 6;
    localparam int BIT_RGP    = 5;
    localparam int BIT_NEG    = 4;
    localparam int BIT_HALT   = 3;
    localparam int BIT_LFILT  = 2;
    localparam int BIT_RSVD1  = 1;
    localparam int BIT_DIR    = 0;
    localparam logic [7:0] CTRL_RESET   = 8'h00;
    localparam logic [7:0] CTRL_WR_MASK = 8'hFE;
    localparam int BIT_NOTIME = 0;

    // ============================================================
    // Interrupt bits
    localparam int IRQ_PARITY   = 0;
    localparam int IRQ_SEL_TO   = 1;
    localparam int IRQ_GAP_TO   = 2;
    localparam int IRQ_W        = 3;

    // ============================================================
    // Timing
    localparam int CLK_NS           = 10;
    localparam int FILT_SHORT_NS    = 30;
    localparam int FILT_LONG_NS     = 60;
    localparam int FILT_SHORT_CYC   = (FILT_SHORT_NS + CLK_NS - 1) / CLK_NS;
    localparam int FILT_LONG_CYC    = (FILT_LONG_NS + CLK_NS - 1) / CLK_NS;
    localparam int SEL_TIMEOUT_CYC  = 4000;
    localparam int GAP_TIMEOUT_CYC  = 2500;
    localparam int HALT_DIV         = 2;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ============================================================
    // Carriers
    typedef struct packed {
        logic       gap_off;
        logic       notime;
        logic       regen_parity;
        logic       neg_en;
        logic       halt;
        logic       long_filt;
    } sctc_cfg_s;

    typedef struct packed {
        logic [7:0] data;
        logic       parity;
    } sctc_byte_s;

    function automatic logic odd_parity(input logic [7:0] d);
        return ~(^d);
    endfunction

endpackage
`default_nettype wire

/* File: design/sctc_hs_filter.sv */
// Purpose: Deasserting-edge glitch filter for one handshake line
// Assumes: Input already synchronised to aclk
// Notes:   Assertion passes at once, deassertion must persist
`timescale 1ns/1ns
`default_nettype none
module sctc_hs_filter (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic long_filt,
    input  wire logic raw,
    output logic      filt
);
    import sctc_pkg::*;

    logic [2:0] cnt, next_cnt, limit;
    logic       next_filt;

    // ============================================================
    // Filter
    always_comb begin
        limit     = long_filt ? 3'(FILT_LONG_CYC) : 3'(FILT_SHORT_CYC);
        next_cnt  = 3'h0;
        next_filt = filt;
        if (raw) begin
            next_filt = 1'b1;
        end else if (filt) begin
            // Short low pulses are glitches and are dropped
            if (cnt + 3'h1 >= limit) begin
                next_filt = 1'b0;
            end else begin
                next_cnt = cnt + 3'h1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt  <= 3'h0;
            filt <= 1'b0;
        end else begin
            cnt  <= next_cnt;
            filt <= next_filt;
        end
    end
endmodule
`default_nettype wire

/* File: design/sctc_core.sv */
// Purpose: Test and control register of a SCSI controller core, AXI4-Lite slave
// Assumes: SCSI side inputs are asynchronous; core logic on aclk
// Notes:   Timers count aclk cycles; interrupts are sticky with write-one clear
//
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

// Function
// - Both timers run after reset or with both disable bits clear.
// - All-timers-off disables selection and byte gap timers.
// - Byte gap disable alone stops only the byte gap timer.
// - Regenerate mode replaces received parity with fresh parity, only while pass-through is set.
// - Bad received parity still raises a parity interrupt.
// - Without regenerate, received parity passes unmodified.
// - Negation enable drives lines deasserted only while driving in transfer phase.
// - Active negation is off after reset or when enable clear.
// - Clock halt stops the divided clock without glitches.
// - Deasserting edges of REQ/ACK filtered 30 ns, or 60 ns when long.
// - Direction bit is read-only: one means SCSI to host.
module sctc_core (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        scsi_req_in,
    input  wire logic        scsi_ack_in,
    input  wire logic [7:0]  scsi_data_in,
    input  wire logic        scsi_parity_in,
    input  wire logic        scsi_to_host,
    input  wire logic        info_phase,
    input  wire logic        drive_active,
    input  wire logic        pass_through,
    input  wire logic        selecting,
    input  wire logic        byte_strobe,
    output logic             req_filt,
    output logic             ack_filt,
    output sctc_pkg::sctc_byte_s fifo_byte,
    output logic             fifo_byte_valid,
    output logic             negate_drive,
    output logic             scsi_div_clk,
    output logic             irq
);
    import sctc_pkg::*;

    // ============================================================
    // Input synchronisers
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic [8:0] dsync1;
    logic [8:0] dsync2;
    logic       req_s, ack_s, dir_s, phase_s, drv_s, pt_s;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1  <= 6'h00;
            sync2  <= 6'h00;
            dsync1 <= 9'h000;
            dsync2 <= 9'h000;
        end else begin
            sync1  <= {scsi_req_in, scsi_ack_in, scsi_to_host, info_phase,
                       drive_active, pass_through};
            sync2  <= sync1;
            dsync1 <= {scsi_parity_in, scsi_data_in};
            dsync2 <= dsync1;
        end
    end

    assign {req_s, ack_s, dir_s, phase_s, drv_s, pt_s} = sync2;

    // ============================================================
    // Register state
    sctc_cfg_s        cfg, next_cfg;
    logic [IRQ_W-1:0] irq_stat, next_irq_stat, irq_en, next_irq_en, irq_set, irq_clr;
    logic [7:0]       ctrl_rd;

    // ============================================================
    // AXI4-Lite write channel
    logic        aw_held, w_held, next_aw_held, next_w_held, next_bvalid, do_write;
    logic [7:0]  aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0]  w_strb, next_w_strb;
    logic [1:0]  next_bresp;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;

    always_comb begin
        next_aw_held = aw_held;
        next_w_held  = w_held;
        next_aw_addr = aw_addr;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = s_axi_bvalid;
        next_bresp   = s_axi_bresp;
        do_write     = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (aw_held && w_held) begin
            do_write     = 1'b1;
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            case ({aw_addr[7:2], 2'b00})
                OFS_CTRL, OFS_COMPANION, OFS_IRQ_EN, OFS_IRQ_CLR: next_bresp = RESP_OKAY;
                OFS_IRQ_STAT, OFS_LINK_STAT:                      next_bresp = RESP_OKAY;
                default:                                          next_bresp = RESP_SLVERR;
            endcase
        end else if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= 8'h00;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else begin
            aw_held      <= next_aw_held;
            w_held       <= next_w_held;
            aw_addr      <= next_aw_addr;
            w_data       <= next_w_data;
            w_strb       <= next_w_strb;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp  <= next_bresp;
        end
    end

    // ============================================================
    // Register writes and interrupt status
    logic wr_lane0;
    assign wr_lane0 = do_write && w_strb[0];

    always_comb begin
        next_cfg    = cfg;
        next_irq_en = irq_en;
        irq_clr     = '0;
        if (wr_lane0) begin
            case ({aw_addr[7:2], 2'b00})
                OFS_CTRL: begin
                    // Direction bit is never stored from a write
                    next_cfg.gap_off      = w_data[BIT_GAPOFF];
                    next_cfg.regen_parity = w_data[BIT_RGP];
                    next_cfg.neg_en       = w_data[BIT_NEG];
                    next_cfg.halt         = w_data[BIT_HALT];
                    next_cfg.long_filt    = w_data[BIT_LFILT];
                end
                OFS_COMPANION: next_cfg.notime = w_data[BIT_NOTIME];
                OFS_IRQ_EN:    next_irq_en     = w_data[IRQ_W-1:0];
                OFS_IRQ_CLR:   irq_clr         = w_data[IRQ_W-1:0];
                default:       next_cfg        = cfg;
            endcase
        end
        // A new event in the clearing cycle survives
        next_irq_stat = (irq_stat & ~irq_clr) | irq_set;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg      <= '0;
            irq_en   <= '0;
            irq_stat <= '0;
        end else begin
            cfg      <= next_cfg;
            irq_en   <= next_irq_en;
            irq_stat <= next_irq_stat;
        end
    end

    assign irq = |(irq_stat & irq_en);

    // ============================================================
    // AXI4-Lite read channel
    logic [31:0] next_rdata;
    logic [1:0]  next_rresp;
    logic        next_rvalid;

    assign s_axi_arready = !s_axi_rvalid;
    assign ctrl_rd = {1'b0, cfg.gap_off, cfg.regen_parity, cfg.neg_en, cfg.halt,
                      cfg.long_filt, 1'b0, dir_s};

    always_comb begin
        next_rdata  = s_axi_rdata;
        next_rresp  = s_axi_rresp;
        next_rvalid = s_axi_rvalid;
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp  = RESP_OKAY;
            case ({s_axi_araddr[7:2], 2'b00})
                OFS_CTRL:      next_rdata = {24'h000000, ctrl_rd};
                OFS_COMPANION: next_rdata = {31'h0, cfg.notime};
                OFS_IRQ_STAT:  next_rdata = {29'h0, irq_stat};
                OFS_IRQ_EN:    next_rdata = {29'h0, irq_en};
                OFS_IRQ_CLR:   next_rdata = 32'h0000_0000;
                OFS_LINK_STAT: next_rdata = {28'h0, req_filt, ack_filt, phase_s, pt_s};
                default: begin
                    next_rdata = 32'h0000_0000;
                    next_rresp = RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
            s_axi_rvalid <= 1'b0;
        end else begin
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= next_rresp;
            s_axi_rvalid <= next_rvalid;
        end
    end

    // ============================================================
    // Handshake filters
    sctc_hs_filter u_req_filt (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .long_filt (cfg.long_filt),
        .raw       (req_s),
        .filt      (req_filt)
    );

    sctc_hs_filter u_ack_filt (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .long_filt (cfg.long_filt),
        .raw       (ack_s),
        .filt      (ack_filt)
    );

    // ============================================================
    // Timers, parity path, negation, divided clock
    logic        sel_en, gap_en, req_d, strobe, bad_par, div_q, next_div_q;
    logic [11:0] sel_cnt, next_sel_cnt, gap_cnt, next_gap_cnt;
    sctc_byte_s  next_fifo_byte;

    assign sel_en = !cfg.notime;
    assign gap_en = !cfg.notime && !cfg.gap_off;
    assign strobe = req_filt && !req_d;
    assign bad_par = dsync2[8] != odd_parity(dsync2[7:0]);

    always_comb begin
        irq_set        = '0;
        next_sel_cnt   = 12'h000;
        next_gap_cnt   = 12'h000;
        next_fifo_byte = fifo_byte;
        if (sel_en && selecting) begin
            next_sel_cnt = sel_cnt + 12'h001;
            if (sel_cnt == 12'(SEL_TIMEOUT_CYC - 1)) begin
                irq_set[IRQ_SEL_TO] = 1'b1;
                next_sel_cnt        = 12'h000;
            end
        end
        if (gap_en && phase_s && !byte_strobe) begin
            next_gap_cnt = gap_cnt + 12'h001;
            if (gap_cnt == 12'(GAP_TIMEOUT_CYC - 1)) begin
                irq_set[IRQ_GAP_TO] = 1'b1;
                next_gap_cnt        = 12'h000;
            end
        end
        if (strobe && dir_s) begin
            next_fifo_byte.data = dsync2[7:0];
            if (pt_s && cfg.regen_parity) begin
                next_fifo_byte.parity = odd_parity(dsync2[7:0]);
            end else begin
                next_fifo_byte.parity = dsync2[8];
            end
            irq_set[IRQ_PARITY] = bad_par;
        end
        // Toggle only when not halted; the output simply holds its level
        next_div_q = cfg.halt ? div_q : !div_q;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_cnt         <= 12'h000;
            gap_cnt         <= 12'h000;
            req_d           <= 1'b0;
            fifo_byte       <= '0;
            fifo_byte_valid <= 1'b0;
            div_q           <= 1'b0;
            negate_drive    <= 1'b0;
        end else begin
            sel_cnt         <= next_sel_cnt;
            gap_cnt         <= next_gap_cnt;
            req_d           <= req_filt;
            fifo_byte       <= next_fifo_byte;
            fifo_byte_valid <= strobe && dir_s;
            div_q           <= next_div_q;
            negate_drive    <= cfg.neg_en && phase_s && drv_s;
        end
    end

    assign scsi_div_clk = div_q;
endmodule
`default_nettype wire

/* File: tb/sctc_core_properties.sv */
// Purpose: Port-level checks for the test and control register block
// Assumes: Bound to sctc_core, one clock domain
// Notes:   Register bits are invisible here, so the bench judges them
`timescale 1ns/1ns
`default_nettype none
module sctc_core_properties (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic       scsi_req_in,
    input wire logic       scsi_ack_in,
    input wire logic       info_phase,
    input wire logic       req_filt,
    input wire logic       ack_filt,
    input wire logic       fifo_byte_valid,
    input wire logic       negate_drive
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ============================================================
    // Properties
    property p_neg_phase;
        (!info_phase)[*5] |-> !negate_drive;
    endproperty
    a_neg_phase: assert property (p_neg_phase)
        else $error("negation driven outside transfer phase");
    property p_neg_reset;
        $rose(aresetn) |-> !negate_drive;
    endproperty
    a_neg_reset: assert property (p_neg_reset)
        else $error("negation on after reset");
    property p_req_rise;
        scsi_req_in[*5] |-> req_filt;
    endproperty
    a_req_rise: assert property (p_req_rise)
        else $error("filtered request missed an assertion");
    // Sync delay is two cycles, so a real fall shows low input three and four back
    property p_req_fall;
        $fell(req_filt) |-> !$past(scsi_req_in, 3) && !$past(scsi_req_in, 4);
    endproperty
    a_req_fall: assert property (p_req_fall)
        else $error("request glitch passed the filter");
    property p_ack_fall;
        $fell(ack_filt) |-> !$past(scsi_ack_in, 3) && !$past(scsi_ack_in, 4);
    endproperty
    a_ack_fall: assert property (p_ack_fall)
        else $error("acknowledge glitch passed the filter");
    property p_fifo_pulse;
        fifo_byte_valid |-> $past(req_filt) && !$past(fifo_byte_valid);
    endproperty
    a_fifo_pulse: assert property (p_fifo_pulse)
        else $error("byte valid without request");
    property p_b_stand;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_stand: assert property (p_b_stand)
        else $error("write response dropped early");
    property p_r_lat;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_r_lat: assert property (p_r_lat)
        else $error("read data late");
endmodule
bind sctc_core sctc_core_properties u_props (
    .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .scsi_req_in(scsi_req_in),
    .scsi_ack_in(scsi_ack_in), .info_phase(info_phase), .req_filt(req_filt),
    .ack_filt(ack_filt), .fifo_byte_valid(fifo_byte_valid), .negate_drive(negate_drive)
);
`default_nettype wire

/* File: tb/sctc_scsi_model.sv */
// Purpose: Far-side bus device driving handshake, data and parity
// Assumes: Tasks are entered just after a rising edge
// Notes:   Released data shows the inverse byte so no stale copy looks valid
`timescale 1ns/1ns
`default_nettype none
module sctc_scsi_model (
    input wire logic       aclk,
    output logic           req = 1'b0,
    output logic           ack = 1'b0,
    output logic [7:0]     data = 8'h00,
    output logic           parity = 1'b0
);
    // ============================================================
    // Transfers
    task automatic send(input logic [7:0] d, input logic bad);
        data <= d;
        parity <= ~(^d) ^ bad;
        @(posedge aclk);
        req <= 1'b1;
        repeat (8) @(posedge aclk);
        req <= 1'b0;
        // Hold data until even the long filter has let the fall through
        repeat (12) @(posedge aclk);
        data <= ~d;
        parity <= (^d) ^ bad;
    endtask
    task automatic glitch(input int n);
        req <= 1'b1;
        ack <= 1'b1;
        repeat (10) @(posedge aclk);
        req <= 1'b0;
        ack <= 1'b0;
        repeat (n) @(posedge aclk);
        req <= 1'b1;
        ack <= 1'b1;
        repeat (12) @(posedge aclk);
    endtask
    task automatic idle;
        req <= 1'b0;
        ack <= 1'b0;
        repeat (12) @(posedge aclk);
    endtask
endmodule
`default_nettype wire

/* File: tb/sctc_core_test.sv */
// Purpose: Self-checking bench for the test and control register block
// Assumes: AXI4-Lite master tasks, far-side model drives the bus lines
// Notes:   Timers run at full length, about 12.5k cycles in all
`timescale 1ns/1ns
`default_nettype none
module sctc_core_test;
    import sctc_pkg::*;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, scsi_req_in, scsi_ack_in, scsi_parity_in, scsi_to_host;
    logic        info_phase, drive_active, pass_through, selecting, byte_strobe, req_filt;
    logic        ack_filt, fifo_byte_valid, negate_drive, scsi_div_clk, irq, rq, ak;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, scsi_data_in;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    sctc_byte_s  fifo_byte, got;
    int          fails, comparisons, drops, ngot;
    sctc_core dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .scsi_req_in,
        .scsi_ack_in, .scsi_data_in, .scsi_parity_in, .scsi_to_host, .info_phase,
        .drive_active, .pass_through, .selecting, .byte_strobe, .req_filt, .ack_filt,
        .fifo_byte, .fifo_byte_valid, .negate_drive, .scsi_div_clk, .irq);
    sctc_scsi_model bus (.aclk, .req(scsi_req_in), .ack(scsi_ack_in),
        .data(scsi_data_in), .parity(scsi_parity_in));
    // ============================================================
    // Helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // Handshakes are judged at the falling edge so the rising edge stays race free
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w, b;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        b = 1'b0;
        while (!b) begin
            @(negedge aclk);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid === 1'b1;
            if (b) check(s_axi_bresp, RESP_OKAY);
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] e);
        logic ar, r;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        r = 1'b0;
        while (!r) begin
            @(negedge aclk);
            ar = s_axi_arvalid && s_axi_arready;
            r = s_axi_rvalid === 1'b1;
            d = s_axi_rdata;
            if (r) check(s_axi_rresp, e);
            @(posedge aclk);
            if (ar) s_axi_arvalid <= 1'b0;
        end
    endtask
    always @(negedge aclk) begin
        drops <= drops + int'(rq & !req_filt) + int'(ak & !ack_filt);
        rq <= req_filt;
        ak <= ack_filt;
        if (fifo_byte_valid === 1'b1) begin
            got <= fifo_byte;
            ngot <= ngot + 1;
        end
    end
    // ============================================================
    // Scenarios
    task automatic reset_case;
        logic [31:0] d;
        rd(OFS_CTRL, d, RESP_OKAY);
        check(d, 32'h0);
        rd(OFS_COMPANION, d, RESP_OKAY);
        check(d, 32'h0);
        rd(8'h18, d, RESP_SLVERR);
        check(d, 32'h0);
    endtask
    task automatic ctrl_case;
        logic [31:0] d;
        scsi_to_host <= 1'b1;
        wr(OFS_CTRL, 32'h7D);
        rd(OFS_CTRL, d, RESP_OKAY);
        check(d & 32'hFD, 32'h7D);
        scsi_to_host <= 1'b0;
        repeat (4) @(posedge aclk);
        rd(OFS_CTRL, d, RESP_OKAY);
        check(d & 32'hFD, 32'h7C);
        wr(OFS_CTRL, 32'h0);
    endtask
    task automatic timer_case(input logic [31:0] c, input logic [31:0] comp, input logic [31:0] e);
        logic [31:0] d;
        wr(OFS_CTRL, c);
        wr(OFS_COMPANION, comp);
        wr(OFS_IRQ_CLR, 32'h7);
        byte_strobe <= 1'b1;
        selecting <= 1'b1;
        info_phase <= 1'b1;
        @(posedge aclk);
        byte_strobe <= 1'b0;
        repeat (SEL_TIMEOUT_CYC + 20) @(posedge aclk);
        selecting <= 1'b0;
        info_phase <= 1'b0;
        rd(OFS_IRQ_STAT, d, RESP_OKAY);
        check(d & 32'h6, e);
        check(irq, e != 0);
    endtask
    task automatic mask_case;
        logic [31:0] d;
        wr(OFS_IRQ_EN, 32'h0);
        check(irq, 1'b0);
        wr(OFS_IRQ_EN, 32'h7);
        wr(OFS_IRQ_CLR, 32'h7);
        rd(OFS_IRQ_STAT, d, RESP_OKAY);
        check(d, 32'h0);
        check(irq, 1'b0);
    endtask
    task automatic parity_case(input logic regen);
        logic [31:0] d;
        wr(OFS_CTRL, {26'h0, regen, 5'h0});
        wr(OFS_IRQ_CLR, 32'h7);
        ngot = 0;
        bus.send(8'hA5, 1'b1);
        check(ngot, 1);
        check(got, {8'hA5, regen});
        rd(OFS_IRQ_STAT, d, RESP_OKAY);
        check(d[0], 1'b1);
    endtask
    task automatic neg_case(input logic [31:0] c, input logic ip, input logic da, input logic e);
        wr(OFS_CTRL, c);
        info_phase <= ip;
        drive_active <= da;
        repeat (6) @(posedge aclk);
        check(negate_drive, e);
    endtask
    task automatic filt_case(input logic lf, input int n, input int e);
        wr(OFS_CTRL, {29'h0, lf, 2'b00});
        drops = 0;
        bus.glitch(n);
        check(drops, e);
        bus.idle;
    endtask
    task automatic halt_case;
        logic a;
        @(negedge aclk);
        a = scsi_div_clk;
        @(negedge aclk);
        check(scsi_div_clk, !a);
        @(posedge aclk);
        wr(OFS_CTRL, 32'h8);
        repeat (3) @(negedge aclk);
        a = scsi_div_clk;
        repeat (6) @(negedge aclk);
        check(scsi_div_clk, a);
        @(posedge aclk);
        wr(OFS_CTRL, 32'h0);
    endtask
    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ============================================================
    // Run
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
        {scsi_to_host, info_phase, drive_active, pass_through} = '0;
        {selecting, byte_strobe, rq, ak, s_axi_awaddr, s_axi_araddr} = '0;
        {s_axi_wdata, fails, comparisons, drops, ngot} = '0;
        {s_axi_wstrb, s_axi_bready, s_axi_rready} = 6'h3F;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        reset_case;
        ctrl_case;
        filt_case(1'b0, 2, 0);
        filt_case(1'b0, 6, 2);
        filt_case(1'b1, 5, 0);
        filt_case(1'b1, 9, 2);
        wr(OFS_IRQ_EN, 32'h7);
        timer_case(32'h0, 32'h0, 32'h6);
        mask_case;
        timer_case(32'h40, 32'h0, 32'h2);
        timer_case(32'h0, 32'h1, 32'h0);
        wr(OFS_COMPANION, 32'h0);
        pass_through <= 1'b1;
        scsi_to_host <= 1'b1;
        parity_case(1'b0);
        parity_case(1'b1);
        neg_case(32'h10, 1'b1, 1'b1, 1'b1);
        neg_case(32'h10, 1'b0, 1'b1, 1'b0);
        neg_case(32'h10, 1'b1, 1'b0, 1'b0);
        neg_case(32'h0, 1'b1, 1'b1, 1'b0);
        halt_case;
        finish_test;
    end
    initial begin
        repeat (40000) @(posedge aclk);
        fails++;
        finish_test;
    end
endmodule
`default_nettype wire
